// >>> design/wdts_watchdog.sv
`timescale 1ns/1ns
module wdts_watchdog
  import wdts_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic      [1:0]  hresp_o,
  input  wire logic        rc_clk_i,
  input  wire logic        config_enable_i,
  input  wire logic        ost_active_i,
  input  wire logic        clear_watchdog_instruction_i,
  input  wire logic        sleep_i,
  input  wire logic        wake_i,
  input  wire logic        osc_fail_i,
  output logic             wdt_reset_o,
  output logic             wake_o,
  output logic             timeout_flag_o,
  output logic             powerdown_flag_o,
  output logic             enabled_o,
  output logic      [7:0]  option_o
);

  wdts_scale_if sc ();

  // Bus slave state.
  wdts_bus_t   bus_q;
  wdts_bus_t   bus_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic        wr_pend_q;
  logic        wr_pend_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        accept;
  logic [31:0] rd_mux;

  // Software registers.
  logic [7:0]  option_q;
  logic [7:0]  option_d;
  logic [7:0]  wdctrl_q;
  logic [7:0]  wdctrl_d;

  // Slow clock synchroniser and edge detect.
  logic        rc_s1_q;
  logic        rc_s2_q;
  logic        rc_s3_q;

  // Counting and flags.
  logic [WDTS_POST_W-1:0] post_q;
  logic [WDTS_POST_W-1:0] post_d;
  logic [WDTS_POST_W-1:0] post_limit;
  logic                   ost_q;
  logic                   ost_d;
  logic                   to_q;
  logic                   to_d;
  logic                   pd_q;
  logic                   pd_d;
  logic                   asleep_q;
  logic                   asleep_d;
  logic                   rst_pulse_q;
  logic                   rst_pulse_d;
  logic                   wake_pulse_q;
  logic                   wake_pulse_d;
  logic                   rc_tick;
  logic                   enabled;
  logic                   running;
  logic                   ost_fall;
  logic                   post_assigned;
  logic                   post_clear;
  logic                   post_term;
  logic                   timeout_ev;

  // SEQ starts a transfer like NONSEQ; only single word transfers are expected here.
  assign accept = hsel_i & hready_i & (htrans_i == WDTS_HTRANS_NONSEQ || htrans_i == 2'h3);

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (addr_q)
      WDTS_OPTION_ADDR:
      begin
        rd_mux = {24'h000000, option_q};
      end
      WDTS_WDCTRL_ADDR:
      begin
        rd_mux = {24'h000000, wdctrl_q & WDTS_WDCTRL_WMASK};
      end
      WDTS_STATUS_ADDR:
      begin
        rd_mux[WDTS_ST_TIMEOUT_BIT] = to_q;
        rd_mux[WDTS_ST_PWRDN_BIT] = pd_q;
        rd_mux[WDTS_ST_ENABLED_BIT] = enabled;
        rd_mux[WDTS_ST_ASLEEP_BIT] = asleep_q;
      end
      default:
      begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Reads take one wait state so that the returned word is a flop, and a read
  // right after a write to the same register already sees the new value.
  always_comb
  begin
    bus_d = bus_q;
    addr_d = addr_q;
    rdata_d = rdata_q;
    wr_pend_d = 1'b0;
    case (bus_q)
      WDTS_BUS_IDLE:
      begin
        if (accept)
        begin
          addr_d = haddr_i;
          wr_pend_d = hwrite_i;
          if (!hwrite_i)
          begin
            bus_d = WDTS_BUS_RDWAIT;
          end
        end
      end
      WDTS_BUS_RDWAIT:
      begin
        rdata_d = rd_mux;
        bus_d = WDTS_BUS_IDLE;
      end
      default:
      begin
        bus_d = WDTS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_q <= WDTS_BUS_IDLE;
      addr_q <= 32'h00000000;
      wr_pend_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      bus_q <= bus_d;
      addr_q <= addr_d;
      wr_pend_q <= wr_pend_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_o = rdata_q;
  assign hreadyout_o = (bus_q == WDTS_BUS_IDLE);
  // Every access ends OKAY: an unmapped address reads zero instead of raising an error.
  assign hresp_o = WDTS_HRESP_OKAY;

  // Only the low byte of a word write lands; other byte lanes are ignored.
  always_comb
  begin
    option_d = option_q;
    wdctrl_d = wdctrl_q;
    if (wr_pend_q && addr_q == WDTS_OPTION_ADDR)
    begin
      option_d = hwdata_i[7:0];
    end
    if (wr_pend_q && addr_q == WDTS_WDCTRL_ADDR)
    begin
      wdctrl_d = hwdata_i[7:0] & WDTS_WDCTRL_WMASK;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      option_q <= WDTS_OPTION_RST;
      wdctrl_q <= WDTS_WDCTRL_RST;
    end
    else
    begin
      option_q <= option_d;
      wdctrl_q <= wdctrl_d;
    end
  end

  // The slow oscillator is foreign to mclk; only its synchronised rising edge
  // is counted, so the system clock choice cannot alter the period.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end
    else
    begin
      rc_s1_q <= rc_clk_i;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  // The detector starts low, matching the idle oscillator level, so no false tick follows reset.
  assign rc_tick = rc_s2_q & ~rc_s3_q;

  assign enabled = config_enable_i | wdctrl_q[WDTS_SOFT_EN_BIT];
  // The start-up timer borrows the ripple counter, so counting waits until it has finished.
  assign running = enabled & ~ost_active_i;
  assign ost_fall = ost_q & ~ost_active_i;
  assign post_assigned = option_q[WDTS_ASSIGN_BIT];

  // The prescaler is always in the watchdog path, so the shared scaler may
  // serve timer zero while the watchdog still has its own divide.
  assign sc.period_code = wdctrl_q[WDTS_PERIOD_LSB +: WDTS_PERIOD_W];
  assign sc.tick = rc_tick & running;
  assign sc.clear = ~running
                  | clear_watchdog_instruction_i
                  | osc_fail_i
                  | ost_fall
                  | (sleep_i & enabled);

  wdts_prescaler u_prescaler
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .sc      (sc)
  );

  // The postscaler counts prescaler terminals only, so a long ratio needs no wider prescaler.
  assign post_limit = WDTS_POST_W'((9'h001 << option_q[WDTS_RATIO_LSB +: WDTS_RATIO_W]) - 9'h001);
  assign post_term = ~post_assigned | (post_q == post_limit);
  assign post_clear = ~running | ~post_assigned | clear_watchdog_instruction_i | ost_fall | (sleep_i & enabled);

  // A clear in the same cycle as the last tick wins: a serviced dog never bites.
  assign timeout_ev = sc.terminal & post_term & ~sc.clear;

  always_comb
  begin
    post_d = post_q;
    if (post_clear)
    begin
      post_d = '0;
    end
    else if (sc.terminal)
    begin
      post_d = (post_q == post_limit) ? '0 : post_q + 8'h01;
    end
  end

  // Sleep outranks a same-cycle time-out, so the flags always show the sleep entry.
  always_comb
  begin
    to_d = to_q;
    pd_d = pd_q;
    asleep_d = asleep_q;
    rst_pulse_d = 1'b0;
    wake_pulse_d = 1'b0;
    ost_d = ost_active_i;
    if (wake_i)
    begin
      asleep_d = 1'b0;
    end
    if (sleep_i)
    begin
      pd_d = 1'b0;
      to_d = 1'b1;
      asleep_d = 1'b1;
    end
    else if (timeout_ev)
    begin
      to_d = 1'b0;
      if (asleep_q)
      begin
        wake_pulse_d = 1'b1;
        asleep_d = 1'b0;
      end
      else
      begin
        rst_pulse_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      post_q <= '0;
      ost_q <= 1'b0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
      asleep_q <= 1'b0;
      rst_pulse_q <= 1'b0;
      wake_pulse_q <= 1'b0;
    end
    else
    begin
      post_q <= post_d;
      ost_q <= ost_d;
      to_q <= to_d;
      pd_q <= pd_d;
      asleep_q <= asleep_d;
      rst_pulse_q <= rst_pulse_d;
      wake_pulse_q <= wake_pulse_d;
    end
  end

  assign wdt_reset_o = rst_pulse_q;
  assign wake_o = wake_pulse_q;
  assign timeout_flag_o = to_q;
  assign powerdown_flag_o = pd_q;
  assign enabled_o = enabled;
  assign option_o = option_q;

endmodule

// >>> design/wdts_pkg.sv
package wdts_pkg;

  // Nominal rate of the slow internal oscillator that times the watchdog.
  localparam int unsigned WDTS_RC_FREQ_HZ = 31250;

  // Printed register offsets are word indices; byte address is four times each.
  localparam logic [11:0] WDTS_OPTION_IDX = 12'h081;
  localparam logic [11:0] WDTS_WDCTRL_IDX = 12'h105;
  localparam logic [11:0] WDTS_STATUS_IDX = 12'h010;
  localparam logic [31:0] WDTS_OPTION_ADDR = {18'h00000, WDTS_OPTION_IDX, 2'b00};
  localparam logic [31:0] WDTS_WDCTRL_ADDR = {18'h00000, WDTS_WDCTRL_IDX, 2'b00};
  localparam logic [31:0] WDTS_STATUS_ADDR = {18'h00000, WDTS_STATUS_IDX, 2'b00};

  localparam logic [7:0] WDTS_OPTION_RST = 8'hff;
  localparam logic [7:0] WDTS_WDCTRL_RST = 8'h08;
  localparam logic [7:0] WDTS_WDCTRL_WMASK = 8'h1f;

  // Field positions.
  localparam int unsigned WDTS_SOFT_EN_BIT = 0;
  localparam int unsigned WDTS_PERIOD_LSB = 1;
  localparam int unsigned WDTS_PERIOD_W = 4;
  localparam int unsigned WDTS_ASSIGN_BIT = 3;
  localparam int unsigned WDTS_RATIO_LSB = 0;
  localparam int unsigned WDTS_RATIO_W = 3;
  localparam int unsigned WDTS_ST_TIMEOUT_BIT = 0;
  localparam int unsigned WDTS_ST_PWRDN_BIT = 1;
  localparam int unsigned WDTS_ST_ENABLED_BIT = 2;
  localparam int unsigned WDTS_ST_ASLEEP_BIT = 3;

  // Prescaler: code 0 divides by 2**5, last doubling code, then the 1:1 code.
  localparam int unsigned WDTS_PRESC_W = 16;
  localparam int unsigned WDTS_PRESC_MIN_LOG2 = 5;
  localparam logic [3:0] WDTS_PERIOD_MAX_CODE = 4'hb;
  localparam logic [3:0] WDTS_PERIOD_UNITY = 4'hc;
  localparam int unsigned WDTS_POST_W = 8;

  localparam logic [1:0] WDTS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] WDTS_HRESP_OKAY = 2'h0;

  typedef enum logic [0:0]
  {
    WDTS_BUS_IDLE = 1'b0,
    WDTS_BUS_RDWAIT = 1'b1
  } wdts_bus_t;

endpackage

// >>> design/wdts_scale_if.sv
`timescale 1ns/1ns
interface wdts_scale_if;
  import wdts_pkg::*;
  logic                     tick;
  logic                     clear;
  logic [WDTS_PERIOD_W-1:0] period_code;
  logic                     terminal;

  modport ctrl
  (
    output tick,
    output clear,
    output period_code,
    input  terminal
  );

  modport scaler
  (
    input  tick,
    input  clear,
    input  period_code,
    output terminal
  );
endinterface

// >>> design/wdts_prescaler.sv
`timescale 1ns/1ns
module wdts_prescaler
  import wdts_pkg::*;
(
  input  wire logic   mclk_i,
  input  wire logic   rst_n_i,
  wdts_scale_if.scaler sc
);

  logic [WDTS_PRESC_W-1:0] cnt_q;
  logic [WDTS_PRESC_W-1:0] cnt_d;
  logic [WDTS_PRESC_W-1:0] limit;
  logic                    at_limit;

  always_comb
  begin
    limit = '0;
    // Codes past the unity code are undefined; they are treated as 1:1.
    if (sc.period_code <= WDTS_PERIOD_MAX_CODE)
    begin
      limit = WDTS_PRESC_W'((17'h00001 << (WDTS_PRESC_MIN_LOG2 + 32'(sc.period_code))) - 17'h00001);
    end
    at_limit = (cnt_q == limit);
    sc.terminal = sc.tick & at_limit;
    cnt_d = cnt_q;
    if (sc.clear)
    begin
      cnt_d = '0;
    end
    else if (sc.tick)
    begin
      cnt_d = at_limit ? '0 : cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// >>> dv/wdts_assertions.sv
`timescale 1ns/1ns
module wdts_chk
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic config_enable_i,
  input wire logic ost_active_i,
  input wire logic clear_watchdog_instruction_i,
  input wire logic sleep_i,
  input wire logic wdt_reset_o,
  input wire logic wake_o,
  input wire logic timeout_flag_o,
  input wire logic powerdown_flag_o,
  input wire logic enabled_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  rst_single_a: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("device reset pulse too long");
  wake_single_a: assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  rst_flag_a: assert property (wdt_reset_o |-> !timeout_flag_o)
    else $error("timeout flag not cleared on reset");
  wake_flag_a: assert property (wake_o |-> !timeout_flag_o && !wdt_reset_o)
    else $error("wake without flag clear");
  sleep_flags_a: assert property (sleep_i && enabled_o |=> timeout_flag_o && !powerdown_flag_o)
    else $error("sleep flags wrong");
  off_quiet_a: assert property (!enabled_o |=> !wdt_reset_o && !wake_o)
    else $error("event while disabled");
  ost_hold_a: assert property (ost_active_i |=> !wdt_reset_o && !wake_o)
    else $error("event during start-up");
  clear_quiet_a: assert property (clear_watchdog_instruction_i |=> !wdt_reset_o && !wake_o)
    else $error("event after clear");
  cfg_on_a: assert property (config_enable_i |-> enabled_o)
    else $error("config enable ignored");

  cover property (wdt_reset_o);
  cover property (wake_o);
  cover property (sleep_i && enabled_o);
endmodule

bind wdts_watchdog wdts_chk chk_u (.mclk_i, .rst_n_i, .config_enable_i, .ost_active_i, .clear_watchdog_instruction_i,
  .sleep_i, .wdt_reset_o, .wake_o, .timeout_flag_o, .powerdown_flag_o, .enabled_o);

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench;
  import wdts_pkg::*;
  logic        mclk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0;
  logic [1:0]  htrans_i = 0;
  logic [2:0]  hsize_i = 3'h2;
  logic        rc_clk_i = 0, config_enable_i = 0, ost_active_i = 0;
  logic        clear_watchdog_instruction_i = 0, sleep_i = 0, wake_i = 0, osc_fail_i = 0;
  logic [31:0] hrdata_o;
  logic [1:0]  hresp_o;
  logic        hreadyout_o, wdt_reset_o, wake_o, timeout_flag_o;
  logic        powerdown_flag_o, enabled_o, rdy_q;
  logic [7:0]  option_o;
  logic [31:0] rd_q;
  int          n_fail = 0, tests_run = 0, n_rst = 0, n_wk = 0, r, k;

  wdts_watchdog dut_u (.mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
    .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .rc_clk_i,
    .config_enable_i, .ost_active_i, .clear_watchdog_instruction_i, .sleep_i, .wake_i, .osc_fail_i, .wdt_reset_o,
    .wake_o, .timeout_flag_o, .powerdown_flag_o, .enabled_o, .option_o);

  always #20 mclk_i = ~mclk_i;

  // Sampling half a cycle ahead avoids racing the flops that update on the rising edge.
  always @(negedge mclk_i)
  begin
    rdy_q = hreadyout_o;
    rd_q = hrdata_o;
    if (wdt_reset_o === 1'b1) n_rst++;
    if (wake_o === 1'b1) n_wk++;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= WDTS_HTRANS_NONSEQ;
    do @(posedge mclk_i); while (rdy_q !== 1'b1);
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= {24'h000000, d};
    do @(posedge mclk_i); while (rdy_q !== 1'b1);
  endtask

  task rd(input logic [31:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd_q, {24'h000000, e});
    chk({30'h00000000, hresp_o}, {30'h00000000, WDTS_HRESP_OKAY});
  endtask

  // One slow-oscillator period spans ten system clocks.
  task tick(input int n);
    repeat (n)
    begin
      rc_clk_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      rc_clk_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
    end
  endtask

  task tout(input int n, input logic w);
    int r0, k0;
    r0 = n_rst;
    k0 = n_wk;
    tick(n - 1);
    chk(n_rst + n_wk, r0 + k0);
    tick(1);
    chk(n_rst, r0 + (w ? 0 : 1));
    chk(n_wk, k0 + (w ? 1 : 0));
  endtask

  task finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge mclk_i);
    n_fail++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(WDTS_OPTION_ADDR, 8'hff);
    rd(WDTS_WDCTRL_ADDR, 8'h08);
    rd(WDTS_STATUS_ADDR, 8'h03);
    rd(32'h00000100, 8'h00);
    bus(1'b1, WDTS_WDCTRL_ADDR, 8'hff);
    rd(WDTS_WDCTRL_ADDR, 8'h1f);
    bus(1'b1, WDTS_OPTION_ADDR, 8'h00);
    for (r = 0; r < 6; r++)
    begin
      k = (r == 5) ? 12 : r;
      bus(1'b1, WDTS_WDCTRL_ADDR, {3'h0, k[3:0], 1'b1});
      tout((k == 12) ? 1 : (32 << k), 1'b0);
    end
    rd(WDTS_STATUS_ADDR, 8'h06);
    bus(1'b1, WDTS_OPTION_ADDR, 8'h0a);
    bus(1'b1, WDTS_WDCTRL_ADDR, 8'h01);
    tout(128, 1'b0);
    chk({24'h000000, option_o}, 32'h0000000a);
    bus(1'b1, WDTS_OPTION_ADDR, 8'h00);
    for (k = 0; k < 2; k++)
    begin
      tick(20);
      {clear_watchdog_instruction_i, osc_fail_i} <= (k == 0) ? 2'b10 : 2'b01;
      @(posedge mclk_i);
      {clear_watchdog_instruction_i, osc_fail_i} <= 2'b00;
      tout(32, 1'b0);
    end
    ost_active_i <= 1'b1;
    r = n_rst;
    tick(40);
    chk(n_rst, r);
    ost_active_i <= 1'b0;
    tout(32, 1'b0);
    bus(1'b1, WDTS_WDCTRL_ADDR, 8'h00);
    r = n_rst;
    tick(40);
    chk(n_rst, r);
    rd(WDTS_STATUS_ADDR, 8'h02);
    config_enable_i <= 1'b1;
    tout(32, 1'b0);
    config_enable_i <= 1'b0;
    bus(1'b1, WDTS_WDCTRL_ADDR, 8'h01);
    tick(20);
    sleep_i <= 1'b1;
    @(posedge mclk_i);
    sleep_i <= 1'b0;
    rd(WDTS_STATUS_ADDR, 8'h0d);
    tout(32, 1'b1);
    rd(WDTS_STATUS_ADDR, 8'h04);
    chk({29'h00000000, enabled_o, powerdown_flag_o, timeout_flag_o}, 32'h00000004);
    sleep_i <= 1'b1;
    @(posedge mclk_i);
    sleep_i <= 1'b0;
    wake_i <= 1'b1;
    @(posedge mclk_i);
    wake_i <= 1'b0;
    rd(WDTS_STATUS_ADDR, 8'h05);
    tout(32, 1'b0);
    finish_test();
  end
endmodule
